//--- core/tsb_fifo.v
`timescale 1ns/100ps
`default_nettype none
module tsb_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [WIDTH-1:0] out_data_reg,
    output reg out_valid_reg,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr_reg;
    reg [AW-1:0] rptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    // ----------------------------------------
    // handshake terms
    // ----------------------------------------
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign push = in_valid && in_ready;
    assign pop = (count_reg != {(AW+1){1'b0}}) && (!out_valid_reg || out_ready);
    // storage write
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end
    // pointers, fill level and output stage
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            wptr_reg <= {AW{1'b0}};
            rptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            out_valid_reg <= 1'b0;
            out_data_reg <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rptr_reg <= rptr_reg + {{(AW-1){1'b0}}, 1'b1};
                out_data_reg <= mem[rptr_reg];
                out_valid_reg <= 1'b1;
            end else if (out_ready) begin
                out_valid_reg <= 1'b0;
            end
            if (push && !pop) begin
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

//--- core/tsb_map.vh
`ifndef TSB_MAP_VH
`define TSB_MAP_VH
// ----------------------------------------
// address byte layout
// ----------------------------------------
`define TSB_TYPE_SENSOR 4'h9
`define TSB_TYPE_EEPROM 4'hA
`define TSB_ADDR_TYPE_HI 7
`define TSB_ADDR_TYPE_LO 4
`define TSB_ADDR_STRAP_HI 3
`define TSB_ADDR_STRAP_LO 1
`define TSB_ADDR_RW_BIT 0
// ----------------------------------------
// sensor pointer values
// ----------------------------------------
`define TSB_PTR_TEMP 2'h0
`define TSB_PTR_CONFIG 2'h1
`define TSB_CFG_RES_HI 6
`define TSB_CFG_RES_LO 5
// ----------------------------------------
// reset values
// ----------------------------------------
`define TSB_RESULT_RST 16'h0000
`define TSB_PTR_RST 2'h0
`define TSB_RES_RST 2'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define TSB_CLK_MHZ 40
`define TSB_CONV9_US 25
`define TSB_CONV9_CYCLES (`TSB_CONV9_US * `TSB_CLK_MHZ)
`define TSB_BITS_PER_BYTE 4'h8
// ----------------------------------------
// receive buffer
// ----------------------------------------
`define TSB_FIFO_WIDTH 8
`define TSB_FIFO_DEPTH 16
`define TSB_FIFO_AW 4
`endif

//--- core/tsb_slave.v
`timescale 1ns/100ps
`include "tsb_map.vh"
`default_nettype none
module tsb_slave #(
    parameter CONV9_CYCLES = `TSB_CONV9_CYCLES
) (
    input wire clk_sys,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_reg,
    input wire [2:0] addr_strap_pins,
    input wire stored_resolution_hi,
    input wire stored_resolution_lo,
    output wire resolution_select_hi,
    output wire resolution_select_lo,
    input wire [11:0] temp_adc,
    output reg conv_done_reg,
    output wire [15:0] temp_result,
    output wire bus_idle,
    output wire [7:0] ee_wr_data,
    output wire ee_wr_valid,
    input wire ee_wr_ready,
    input wire [7:0] ee_rd_data,
    output wire ee_rd_take
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_ACK = 6'h04;
    localparam [5:0] ST_WRX = 6'h08;
    localparam [5:0] ST_TX = 6'h10;
    localparam [5:0] ST_MACK = 6'h20;
    // ----------------------------------------
    // functions
    // ----------------------------------------
    // keep 9 to 12 top bits of the left-justified result
    function [15:0] res_mask;
        input [1:0] res;
        begin
            case (res)
                2'h0: res_mask = 16'hFF80;
                2'h1: res_mask = 16'hFFC0;
                2'h2: res_mask = 16'hFFE0;
                default: res_mask = 16'hFFF0;
            endcase
        end
    endfunction
    // conversion length doubles per extra bit
    function [17:0] conv_len;
        input [1:0] res;
        reg [17:0] base;
        begin
            base = CONV9_CYCLES[17:0];
            conv_len = base << res;
        end
    endfunction
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg scl_s1_reg;
    reg scl_s2_reg;
    reg scl_q_reg;
    reg sda_s1_reg;
    reg sda_s2_reg;
    reg sda_q_reg;
    reg [2:0] strap_s1_reg;
    reg [2:0] strap_s2_reg;
    reg [5:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] rx_shift_reg;
    reg [7:0] tx_shift_reg;
    reg is_read_reg;
    reg is_sensor_reg;
    reg first_wr_reg;
    reg ack_good_reg;
    reg lsb_next_reg;
    reg [1:0] ptr_reg;
    reg [1:0] res_reg;
    reg res_load_reg;
    reg [15:0] result_reg;
    reg [15:0] snap_reg;
    reg [17:0] conv_cnt_reg;
    reg fifo_push_reg;
    reg [7:0] fifo_data_reg;
    reg rd_take_reg;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire addr_match;
    wire type_sensor;
    wire type_eeprom;
    wire fifo_in_ready;
    wire [7:0] next_tx;
    wire [15:0] result_now;
    // ----------------------------------------
    // input synchronisers and edges
    // ----------------------------------------
    // two stages per pin, third stage on clock and data only for edge finding
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_q_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            strap_s1_reg <= 3'h0;
            strap_s2_reg <= 3'h0;
        end else begin
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
            scl_q_reg <= scl_s2_reg;
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
            sda_q_reg <= sda_s2_reg;
            strap_s1_reg <= addr_strap_pins;
            strap_s2_reg <= strap_s1_reg;
        end
    end
    assign scl_rise = scl_s2_reg && !scl_q_reg;
    assign scl_fall = !scl_s2_reg && scl_q_reg;
    // start is data falling with clock high
    assign start_det = scl_s2_reg && scl_q_reg && sda_q_reg && !sda_s2_reg;
    // stop is data rising with clock high
    assign stop_det = scl_s2_reg && scl_q_reg && !sda_q_reg && sda_s2_reg;
    // idle only with both lines high
    assign bus_idle = scl_s2_reg && sda_s2_reg && (state_reg == ST_IDLE);
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // fixed type nibble per target
    assign type_sensor = rx_shift_reg[`TSB_ADDR_TYPE_HI:`TSB_ADDR_TYPE_LO] == `TSB_TYPE_SENSOR;
    assign type_eeprom = rx_shift_reg[`TSB_ADDR_TYPE_HI:`TSB_ADDR_TYPE_LO] == `TSB_TYPE_EEPROM;
    assign addr_match = (type_sensor || type_eeprom)
        && (rx_shift_reg[`TSB_ADDR_STRAP_HI:`TSB_ADDR_STRAP_LO] == strap_s2_reg);
    // ----------------------------------------
    // transmit byte selection
    // ----------------------------------------
    // result always readable, snapshot keeps bytes paired
    assign next_tx = !is_sensor_reg ? ee_rd_data :
        (ptr_reg == `TSB_PTR_CONFIG) ? {1'b0, res_reg, 5'h00} :
        lsb_next_reg ? snap_reg[7:0] : result_reg[15:8];
    // ----------------------------------------
    // serial engine
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            rx_shift_reg <= 8'h00;
            tx_shift_reg <= 8'h00;
            sda_oe_reg <= 1'b0;
            is_read_reg <= 1'b0;
            is_sensor_reg <= 1'b0;
            first_wr_reg <= 1'b0;
            ack_good_reg <= 1'b0;
            lsb_next_reg <= 1'b0;
            ptr_reg <= `TSB_PTR_RST;
            snap_reg <= `TSB_RESULT_RST;
            fifo_push_reg <= 1'b0;
            fifo_data_reg <= 8'h00;
            rd_take_reg <= 1'b0;
            res_load_reg <= 1'b1;
            res_reg <= `TSB_RES_RST;
        end else begin
            fifo_push_reg <= 1'b0;
            rd_take_reg <= 1'b0;
            if (res_load_reg) begin
                res_reg <= {stored_resolution_hi, stored_resolution_lo};
                res_load_reg <= 1'b0;
            end
            if (start_det) begin
                state_reg <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe_reg <= 1'b0;
                lsb_next_reg <= 1'b0;
            end else if (stop_det) begin
                state_reg <= ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        sda_oe_reg <= 1'b0;
                    end
                    ST_ADDR, ST_WRX: begin
                        if (scl_rise && bit_cnt_reg != `TSB_BITS_PER_BYTE) begin
                            rx_shift_reg <= {rx_shift_reg[6:0], sda_s2_reg};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == `TSB_BITS_PER_BYTE) begin
                            // ninth clock is the answer slot
                            bit_cnt_reg <= 4'h0;
                            state_reg <= ST_ACK;
                            if (state_reg == ST_ADDR) begin
                                is_read_reg <= rx_shift_reg[`TSB_ADDR_RW_BIT];
                                is_sensor_reg <= type_sensor;
                                first_wr_reg <= 1'b1;
                                ack_good_reg <= addr_match;
                                sda_oe_reg <= addr_match;
                            end else if (is_sensor_reg && first_wr_reg) begin
                                first_wr_reg <= 1'b0;
                                ptr_reg <= rx_shift_reg[1:0];
                                ack_good_reg <= 1'b1;
                                sda_oe_reg <= 1'b1;
                            end else if (is_sensor_reg) begin
                                if (ptr_reg == `TSB_PTR_CONFIG) begin
                                    res_reg <= rx_shift_reg[`TSB_CFG_RES_HI:`TSB_CFG_RES_LO];
                                    ack_good_reg <= 1'b1;
                                    sda_oe_reg <= 1'b1;
                                end else begin
                                    ack_good_reg <= 1'b0;
                                    sda_oe_reg <= 1'b0;
                                end
                            end else begin
                                // buffer full refuses the byte
                                ack_good_reg <= fifo_in_ready;
                                sda_oe_reg <= fifo_in_ready;
                                fifo_push_reg <= fifo_in_ready;
                                fifo_data_reg <= rx_shift_reg;
                            end
                        end
                    end
                    ST_ACK: begin
                        // hold low through ninth clock high
                        if (scl_fall) begin
                            if (!ack_good_reg) begin
                                sda_oe_reg <= 1'b0;
                                state_reg <= ST_IDLE;
                            end else if (is_read_reg) begin
                                // drive low only for zero bits
                                tx_shift_reg <= {next_tx[6:0], 1'b0};
                                sda_oe_reg <= !next_tx[7];
                                rd_take_reg <= !is_sensor_reg;
                                if (lsb_next_reg == 1'b0) begin
                                    snap_reg <= result_reg;
                                end
                                lsb_next_reg <= !lsb_next_reg;
                                state_reg <= ST_TX;
                            end else begin
                                sda_oe_reg <= 1'b0;
                                state_reg <= ST_WRX;
                            end
                        end
                    end
                    ST_TX: begin
                        // change data only after clock fall
                        if (scl_fall) begin
                            if (bit_cnt_reg == 4'h7) begin
                                bit_cnt_reg <= 4'h0;
                                sda_oe_reg <= 1'b0;
                                state_reg <= ST_MACK;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                                sda_oe_reg <= !tx_shift_reg[7];
                                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            // master high means no more bytes
                            if (sda_s2_reg) begin
                                state_reg <= ST_IDLE;
                                sda_oe_reg <= 1'b0;
                            end else begin
                                // acknowledged, next byte loads on fall
                                state_reg <= ST_ACK;
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        sda_oe_reg <= 1'b0;
                    end
                endcase
            end
        end
    end
    // open drain, output level fixed low
    assign sda_out = 1'b0;
    // ----------------------------------------
    // conversion timer and result
    // ----------------------------------------
    // signed 12-bit value, left justified
    assign result_now = {temp_adc, 4'h0} & res_mask(res_reg);
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            conv_cnt_reg <= 18'h00000;
            result_reg <= `TSB_RESULT_RST;
            conv_done_reg <= 1'b0;
        end else begin
            conv_done_reg <= 1'b0;
            if (conv_cnt_reg >= conv_len(res_reg) - 18'h00001) begin
                conv_cnt_reg <= 18'h00000;
                result_reg <= result_now;
                conv_done_reg <= 1'b1;
            end else begin
                conv_cnt_reg <= conv_cnt_reg + 18'h00001;
            end
        end
    end
    assign temp_result = result_reg;
    assign resolution_select_hi = res_reg[1];
    assign resolution_select_lo = res_reg[0];
    assign ee_rd_take = rd_take_reg;
    // ----------------------------------------
    // receive buffer toward the EEPROM side
    // ----------------------------------------
    tsb_fifo #(.WIDTH(`TSB_FIFO_WIDTH), .DEPTH(`TSB_FIFO_DEPTH), .AW(`TSB_FIFO_AW)) u_fifo (
        .clk_sys(clk_sys), .rst_n(rst_n), .in_data(fifo_data_reg), .in_valid(fifo_push_reg),
        .in_ready(fifo_in_ready), .out_data_reg(ee_wr_data), .out_valid_reg(ee_wr_valid),
        .out_ready(ee_wr_ready)
    );
endmodule
`default_nettype wire

//--- core/tsb_unused.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- verification/tsb_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// bus master model
// ----------------------------------------
module tsb_master_model (
    input wire logic clk_sys,
    input wire logic dev_oe,
    output var logic scl,
    output wire logic sda
);
    logic sda_low = 1'h0;
    initial scl = 1'h1;
    // open drain wire with pull-up
    assign sda = !(sda_low | dev_oe);
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic start_cond();
        wait_n(2);
        sda_low = 1'h0;
        wait_n(2);
        scl = 1'h1;
        wait_n(4);
        sda_low = 1'h1;
        wait_n(4);
        scl = 1'h0;
    endtask
    // clock stands high after the stop
    task automatic stop_cond();
        wait_n(2);
        sda_low = 1'h1;
        wait_n(2);
        scl = 1'h1;
        wait_n(4);
        sda_low = 1'h0;
        wait_n(4);
    endtask
    task automatic bit_cycle(input logic b, output logic r);
        wait_n(2);
        sda_low = !b;
        wait_n(2);
        scl = 1'h1;
        wait_n(2);
        r = sda;
        wait_n(2);
        scl = 1'h0;
    endtask
    task automatic byte_xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_cycle(d[i], q[i]);
        bit_cycle(ack_in, ack);
    endtask
endmodule
`default_nettype wire

//--- verification/tsb_slave_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module tsb_slave_sva #(
    parameter CONV9_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_reg,
    input wire logic [2:0] addr_strap_pins,
    input wire logic stored_resolution_hi,
    input wire logic stored_resolution_lo,
    input wire logic resolution_select_hi,
    input wire logic resolution_select_lo,
    input wire logic [11:0] temp_adc,
    input wire logic conv_done_reg,
    input wire logic [15:0] temp_result,
    input wire logic bus_idle,
    input wire logic [7:0] ee_wr_data,
    input wire logic ee_wr_valid,
    input wire logic ee_wr_ready,
    input wire logic [7:0] ee_rd_data,
    input wire logic ee_rd_take
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    wire [1:0] res = {resolution_select_hi, resolution_select_lo};
    reg [15:0] cnt_reg;
    reg seen_reg;
    reg [1:0] res_seen_reg;
    // cycles since the last finished conversion
    always @(posedge clk_sys) begin
        cnt_reg <= (!rst_n || conv_done_reg) ? 16'h0000 : cnt_reg + 16'h0001;
        seen_reg <= rst_n && (seen_reg || conv_done_reg);
        res_seen_reg <= conv_done_reg ? res : res_seen_reg;
    end
    property p_no_high; sda_out == 1'h0; endproperty
    a_no_high: assert property (p_no_high) else $error("data pin driven high");
    property p_oe_scl_low; !$stable(sda_oe_reg) |-> !$past(scl_in, 2); endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data drive moved in clock high");
    property p_idle_free; bus_idle |-> !sda_oe_reg; endproperty
    a_idle_free: assert property (p_idle_free) else $error("idle while pulling data");
    property p_idle_scl; (!scl_in) [*4] |=> !bus_idle; endproperty
    a_idle_scl: assert property (p_idle_scl) else $error("idle with clock low");
    property p_res_load; $rose(rst_n) |=> res == $past({stored_resolution_hi, stored_resolution_lo}); endproperty
    a_res_load: assert property (p_res_load) else $error("resolution not reloaded");
    property p_conv_period; conv_done_reg && seen_reg && res_seen_reg == res |-> cnt_reg == (CONV9_CYCLES << res) - 1; endproperty
    a_conv_period: assert property (p_conv_period) else $error("conversion period wrong");
    property p_result; conv_done_reg && $stable(res) |-> temp_result == ({$past(temp_adc), 4'h0} & ~(16'h007F >> res)); endproperty
    a_result: assert property (p_result) else $error("result value wrong");
    property p_wr_hold; ee_wr_valid && !ee_wr_ready |=> ee_wr_valid && $stable(ee_wr_data); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write byte dropped in stall");
    c_conv: cover property (conv_done_reg);
    c_ack: cover property ($rose(sda_oe_reg));
    c_stall: cover property (ee_wr_valid && !ee_wr_ready);
endmodule
bind tsb_slave tsb_slave_sva #(.CONV9_CYCLES(CONV9_CYCLES)) u_tsb_slave_sva (.*);
`default_nettype wire

//--- verification/tsb_slave_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// testbench top
// ----------------------------------------
module tsb_slave_tb;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic [2:0] strap = 3'h5;
    logic [1:0] stored = 2'h2;
    logic [11:0] temp_adc = 12'h7FF;
    logic ee_wr_ready = 1'h1;
    logic [7:0] ee_rd_data = 8'hC3;
    logic [7:0] q;
    logic ack;
    wire scl, sda, sda_out, sda_oe, res_hi, res_lo, conv_done, bus_idle, ee_wr_valid, ee_rd_take;
    wire [15:0] temp_result;
    wire [7:0] ee_wr_data;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int takes = 0;
    always #12.5 clk_sys = !clk_sys;
    tsb_slave #(.CONV9_CYCLES(20)) u_tsb_slave (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_reg(sda_oe), .addr_strap_pins(strap), .stored_resolution_hi(stored[1]),
        .stored_resolution_lo(stored[0]), .resolution_select_hi(res_hi), .resolution_select_lo(res_lo),
        .temp_adc(temp_adc), .conv_done_reg(conv_done), .temp_result(temp_result), .bus_idle(bus_idle),
        .ee_wr_data(ee_wr_data), .ee_wr_valid(ee_wr_valid), .ee_wr_ready(ee_wr_ready),
        .ee_rd_data(ee_rd_data), .ee_rd_take(ee_rd_take));
    tsb_master_model u_tsb_master_model (.clk_sys(clk_sys), .dev_oe(sda_oe), .scl(scl), .sda(sda));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic xb(input logic [7:0] d, input logic a_in);
        u_tsb_master_model.byte_xfer(d, a_in, q, ack);
    endtask
    task automatic do_reset(input logic [1:0] st);
        rst_n = 1'h0;
        stored = st;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'h1;
        repeat (6) @(negedge clk_sys);
        check({14'h0, res_hi, res_lo}, {14'h0, st});
    endtask
    task automatic t_read_temp(input logic [6:0] addr, input logic [15:0] exp);
        repeat (400) @(negedge clk_sys);
        check(temp_result, exp);
        u_tsb_master_model.start_cond();
        xb({addr, 1'h1}, 1'h1);
        check(ack, 1'h0);
        xb(8'hFF, 1'h0);
        check(q, exp[15:8]);
        xb(8'hFF, 1'h1);
        check(q, exp[7:0]);
        u_tsb_master_model.stop_cond();
        check(bus_idle, 1'h1);
    endtask
    task automatic t_addr_miss();
        logic [6:0] bad [2] = '{7'h4C, 7'h5D};
        u_tsb_master_model.start_cond();
        foreach (bad[i]) begin
            xb({bad[i], 1'h0}, 1'h1);
            check(ack, 1'h1);
            u_tsb_master_model.start_cond();
        end
        xb(8'h9A, 1'h1);
        check(ack, 1'h0);
        u_tsb_master_model.stop_cond();
    endtask
    task automatic t_write_ro();
        u_tsb_master_model.start_cond();
        xb(8'h9A, 1'h1);
        xb(8'h00, 1'h1);
        check(ack, 1'h0);
        xb(8'h55, 1'h1);
        check(ack, 1'h1);
        u_tsb_master_model.stop_cond();
    endtask
    task automatic t_config();
        temp_adc = 12'h801;
        u_tsb_master_model.start_cond();
        xb(8'h9A, 1'h1);
        xb(8'h01, 1'h1);
        xb(8'h60, 1'h1);
        check(ack, 1'h0);
        u_tsb_master_model.start_cond();
        xb(8'h9B, 1'h1);
        xb(8'hFF, 1'h1);
        check(q, 16'h0060);
        u_tsb_master_model.start_cond();
        xb(8'h9A, 1'h1);
        xb(8'h00, 1'h1);
        u_tsb_master_model.stop_cond();
        check({14'h0, res_hi, res_lo}, 16'h0003);
        t_read_temp(7'h4D, 16'h8010);
    endtask
    task automatic t_eeprom_fill();
        int n;
        n = 0;
        ee_wr_ready = 1'h0;
        u_tsb_master_model.start_cond();
        xb(8'hAA, 1'h1);
        while (ack === 1'h0 && n < 20) begin
            xb(n[7:0], 1'h1);
            n++;
        end
        u_tsb_master_model.stop_cond();
        check(n[15:0], 16'h0012);
        ee_wr_ready = 1'h1;
        for (int i = 0; i < n - 1; i++) begin
            for (int k = 0; k < 4 && ee_wr_valid !== 1'h1; k++) @(negedge clk_sys);
            check({8'h00, ee_wr_data}, {8'h00, i[7:0]});
            @(negedge clk_sys);
        end
        repeat (3) @(negedge clk_sys);
        check(ee_wr_valid, 1'h0);
    endtask
    task automatic t_eeprom_read();
        u_tsb_master_model.start_cond();
        xb(8'hAB, 1'h1);
        xb(8'hFF, 1'h1);
        check(q, ee_rd_data);
        u_tsb_master_model.stop_cond();
        check(bus_idle, 1'h1);
        check(takes[15:0], 16'h0001);
    endtask
    // read byte pulses toward the EEPROM side
    always @(posedge clk_sys) begin
        if (ee_rd_take === 1'h1) takes++;
    end
    // cycle ceiling against a hung bus
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    // main sequence
    initial begin
        do_reset(2'h2);
        t_read_temp(7'h4D, 16'h7FE0);
        t_addr_miss();
        t_write_ro();
        t_config();
        t_eeprom_fill();
        t_eeprom_read();
        temp_adc = 12'h7E7;
        do_reset(2'h0);
        t_read_temp(7'h4D, 16'h7E00);
        finish_test();
    end
endmodule
`default_nettype wire
